// ===== cssp_clk_ctrl.v
// Clock switch, fail-safe fallback and Sleep/Idle control.
// Assumes oscillator ready, lock and tick inputs synchronous to core_clk.
`timescale 1ns/10ps
`include "cssp_consts.vh"

module cssp_clk_ctrl #(
  parameter SETTLE = 4
) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_q,
  // Configuration
  input wire switch_enable_fuse,
  input wire failsafe_enable,
  input wire watchdog_enable,
  input wire [5:0] osc_is_crystal,
  // Oscillator status
  input wire [5:0] osc_ready,
  input wire osc_startup_timer_done,
  input wire pll_locked,
  input wire target_clk_tick,
  input wire osc_failed,
  // Power-save instruction and wake sources
  input wire power_save_instr,
  input wire power_save_idle,
  input wire irq_wake,
  input wire watchdog_timeout,
  // Outputs
  output reg [5:0] osc_enable_q,
  output reg [2:0] sys_clk_sel_q,
  output reg sys_clk_run_q,
  output reg cpu_clk_run_q,
  output reg periph_clk_run_q,
  output reg failsafe_active_q,
  output reg clock_fail_trap_q,
  output reg watchdog_clear_q
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_LOCK = 3'h2;
  localparam [2:0] ST_SETTLE = 3'h3;
  localparam [2:0] ST_CHANGE = 3'h4;
  localparam [1:0] PM_RUN = 2'h0;
  localparam [1:0] PM_SLEEP = 2'h1;
  localparam [1:0] PM_IDLE = 2'h2;

  reg [2:0] st_q;
  reg [1:0] pm_q;
  reg [2:0] current_source_sel_q;
  reg [2:0] requested_source_sel_q;
  reg switch_request_q;
  reg clock_fail_flag_q;
  reg pll_lock_flag_q;
  reg secondary_osc_enable_q;
  reg [1:0] unlock_q;
  reg [2:0] prev_src_q;
  reg settle_start_q;
  wire settle_done;
  wire target_pll;
  wire wr_osc;
  wire low_power_rc_osc_need;
  wire fail_event;
  wire wake_event;
  reg wake_hold_q;

  assign target_pll = (requested_source_sel_q == `CSSP_SRC_FAST_RC_WITH_PLL) ||
                      (requested_source_sel_q == `CSSP_SRC_PRIPLL);
  assign wr_osc = reg_wr && (reg_addr == `CSSP_OFF_OSCCTL);
  assign low_power_rc_osc_need = watchdog_enable || failsafe_enable;
  // The monitor output lags Sleep entry by a cycle, so Sleep gates it here
  assign fail_event = failsafe_active_q && osc_failed &&
                      (pm_q != PM_SLEEP) &&
                      (current_source_sel_q != `CSSP_SRC_FRC);
  // A wake that arrived with the power-save instruction is kept one cycle
  assign wake_event = irq_wake || watchdog_timeout || wake_hold_q;

  // Counts target clock edges; the count itself is fixed at ten
  cssp_settle_cnt #(
    .WIDTH(SETTLE),
    .COUNT(`CSSP_SETTLE_CYCLES)
  ) u_settle (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(settle_start_q),
    .tick(target_clk_tick),
    .done_q(settle_done)
  );

  // ----------------------------------------------------------------
  // Register writes, unlock and switch sequencing
  // ----------------------------------------------------------------
  // Unlock: two key writes to the status offset open one control write.
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      unlock_q <= 2'h0;
    end
    else if (reg_wr && reg_addr == `CSSP_OFF_STATUS &&
             reg_wdata[7:0] == `CSSP_KEY1)
    begin
      unlock_q <= 2'h1;
    end
    else if (reg_wr && reg_addr == `CSSP_OFF_STATUS &&
             reg_wdata[7:0] == `CSSP_KEY2 && unlock_q == 2'h1)
    begin
      unlock_q <= 2'h2;
    end
    // Any other write closes the unlock, whether it landed or not
    else if (reg_wr)
    begin
      unlock_q <= 2'h0;
    end
  end

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= ST_IDLE;
      current_source_sel_q <= `CSSP_RST_SRC;
      requested_source_sel_q <= `CSSP_RST_SRC;
      switch_request_q <= 1'b0;
      clock_fail_flag_q <= 1'b0;
      pll_lock_flag_q <= 1'b0;
      secondary_osc_enable_q <= 1'b0;
      prev_src_q <= `CSSP_RST_SRC;
      settle_start_q <= 1'b0;
      clock_fail_trap_q <= 1'b0;
    end
    else
    begin
      settle_start_q <= 1'b0;
      clock_fail_trap_q <= 1'b0;
      pll_lock_flag_q <= pll_locked;
      // Software clear of fail flag; a new failure below wins.
      if (wr_osc && unlock_q == 2'h2 && !reg_wdata[`CSSP_BIT_FAIL])
        clock_fail_flag_q <= 1'b0;
      if (wr_osc && unlock_q == 2'h2)
        secondary_osc_enable_q <= reg_wdata[`CSSP_BIT_SECEN];
      if (wr_osc && unlock_q == 2'h2 && switch_enable_fuse &&
          st_q == ST_IDLE)
      begin
        requested_source_sel_q <= reg_wdata[`CSSP_REQ_HI:`CSSP_REQ_LO];
        switch_request_q <= reg_wdata[`CSSP_BIT_SWREQ];
      end
      // Fuse low: no switching, no monitor, request held at zero
      if (!switch_enable_fuse)
      begin
        switch_request_q <= 1'b0;
        st_q <= ST_IDLE;
      end
      else if (fail_event)
      begin
        // Set wins over a software clear in the same cycle
        clock_fail_flag_q <= 1'b1;
        clock_fail_trap_q <= 1'b1;
        prev_src_q <= current_source_sel_q;
        current_source_sel_q <= `CSSP_SRC_FRC;
        switch_request_q <= 1'b0;
        st_q <= ST_IDLE;
      end
      else if (pm_q != PM_SLEEP)
      begin
        // Sequencing runs in Run and in Idle; only Sleep freezes it
        case (st_q)
          ST_IDLE:
            if (switch_request_q)
            begin
              // Redundant: nothing starts and no flag is touched
              if (requested_source_sel_q == current_source_sel_q)
                switch_request_q <= 1'b0;
              else
              begin
                pll_lock_flag_q <= 1'b0;
                clock_fail_flag_q <= 1'b0;
                st_q <= ST_START;
              end
            end
          ST_START:
            // Stays here with the request set if never ready
            if (osc_ready[requested_source_sel_q] &&
                (!osc_is_crystal[requested_source_sel_q] ||
                 osc_startup_timer_done))
              st_q <= ST_LOCK;
          ST_LOCK:
            if (!target_pll || pll_locked)
            begin
              settle_start_q <= 1'b1;
              st_q <= ST_SETTLE;
            end
          ST_SETTLE:
            // A done left over from the last switch is masked by start
            if (settle_done && !settle_start_q)
              st_q <= ST_CHANGE;
          ST_CHANGE:
          begin
            // The old source leaves the enables on the next cycle
            prev_src_q <= current_source_sel_q;
            current_source_sel_q <= requested_source_sel_q;
            switch_request_q <= 1'b0;
            st_q <= ST_IDLE;
          end
          default:
            st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-save modes
  // ----------------------------------------------------------------
  // Sequencing freezes in Sleep; a pending switch resumes after wake
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pm_q <= PM_RUN; // Any reset wakes
      watchdog_clear_q <= 1'b0;
      wake_hold_q <= 1'b0;
    end
    else
    begin
      watchdog_clear_q <= 1'b0;
      wake_hold_q <= 1'b0;
      case (pm_q)
        PM_RUN:
          if (power_save_instr)
          begin
            pm_q <= power_save_idle ? PM_IDLE : PM_SLEEP;
            watchdog_clear_q <= watchdog_enable;
            // Entry completes first; the held wake then ends it
            wake_hold_q <= irq_wake || watchdog_timeout;
          end
        PM_SLEEP, PM_IDLE:
          // Processor clock returns two cycles after the wake, one cycle after pm_q
          if (wake_event)
            pm_q <= PM_RUN;
        default:
          pm_q <= PM_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock and oscillator outputs
  // ----------------------------------------------------------------
  // Selection is kept across Sleep so wake resumes on the same source.
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      osc_enable_q <= 6'h01;
      sys_clk_sel_q <= `CSSP_RST_SRC;
      sys_clk_run_q <= 1'b1;
      cpu_clk_run_q <= 1'b1;
      periph_clk_run_q <= 1'b1;
      failsafe_active_q <= 1'b0;
    end
    else
    begin
      sys_clk_sel_q <= current_source_sel_q;
      sys_clk_run_q <= (pm_q != PM_SLEEP);
      periph_clk_run_q <= (pm_q != PM_SLEEP);
      cpu_clk_run_q <= (pm_q == PM_RUN);
      failsafe_active_q <= failsafe_enable && switch_enable_fuse &&
                           (pm_q != PM_SLEEP);
      if (pm_q == PM_SLEEP)
      begin
        osc_enable_q <= 6'h00;
        osc_enable_q[`CSSP_SRC_LOW_POWER_RC_OSC] <= watchdog_enable;
        // Secondary keeps running while its enable stays set
        osc_enable_q[`CSSP_SRC_SEC] <= secondary_osc_enable_q;
      end
      else
      begin
        osc_enable_q <= 6'h00; // Old source drops here
        osc_enable_q[current_source_sel_q] <= 1'b1;
        if (st_q != ST_IDLE)
          osc_enable_q[requested_source_sel_q] <= 1'b1;
        if (low_power_rc_osc_need)
          osc_enable_q[`CSSP_SRC_LOW_POWER_RC_OSC] <= 1'b1;
        if (secondary_osc_enable_q)
          osc_enable_q[`CSSP_SRC_SEC] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Unused offsets and cycles without a read strobe return zero
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata_q <= 16'h0000;
    else if (reg_rd && reg_addr == `CSSP_OFF_OSCCTL)
      reg_rdata_q <= {1'b0, current_source_sel_q, 1'b0,
                      requested_source_sel_q, 2'b00, pll_lock_flag_q,
                      1'b0, clock_fail_flag_q, 1'b0,
                      secondary_osc_enable_q, switch_request_q};
    else if (reg_rd && reg_addr == `CSSP_OFF_STATUS)
      reg_rdata_q <= {8'h00, prev_src_q, st_q, pm_q};
    else
      reg_rdata_q <= 16'h0000;
  end

endmodule // cssp_clk_ctrl

// ===== cssp_clk_ctrl_assertions.sv
// Port checker for the clock switch and power-save controller.
// Assumes a bind onto cssp_clk_ctrl; a single clock domain.
`timescale 1ns/10ps
`include "cssp_consts.vh"

module cssp_clk_ctrl_assertions (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Inputs watched
  input wire power_save_instr,
  input wire power_save_idle,
  input wire irq_wake,
  input wire watchdog_enable,
  input wire failsafe_enable,
  input wire switch_enable_fuse,
  // Outputs watched
  input wire [5:0] osc_enable_q,
  input wire [2:0] sys_clk_sel_q,
  input wire sys_clk_run_q,
  input wire cpu_clk_run_q,
  input wire periph_clk_run_q,
  input wire failsafe_active_q,
  input wire clock_fail_trap_q,
  input wire watchdog_clear_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_sleep_req;
    power_save_instr && !power_save_idle && !irq_wake;
  endsequence
  sequence s_idle_req;
    power_save_instr && power_save_idle && !irq_wake;
  endsequence

  chk_trap_pulse: assert property (
    clock_fail_trap_q |=> !clock_fail_trap_q)
    else $error("trap longer than one cycle");
  chk_trap_to_frc: assert property (
    clock_fail_trap_q |-> ##[0:4] sys_clk_sel_q == `CSSP_SRC_FRC)
    else $error("no fallback to fast RC after trap");
  chk_sleep_off: assert property (
    s_sleep_req |-> ##[1:3] (!sys_clk_run_q && !periph_clk_run_q))
    else $error("clocks still running in sleep");
  chk_fs_sleep: assert property (
    !sys_clk_run_q && !$past(sys_clk_run_q) |-> !failsafe_active_q)
    else $error("monitor active in sleep");
  chk_idle_cpu: assert property (
    s_idle_req |-> ##[1:3] (!cpu_clk_run_q && sys_clk_run_q))
    else $error("idle clock states wrong");
  chk_wd_clear: assert property (
    power_save_instr && watchdog_enable |-> ##[0:2] watchdog_clear_q)
    else $error("watchdog not cleared on power save");
  chk_wake_cpu: assert property (
    !cpu_clk_run_q && irq_wake |-> ##[1:3] cpu_clk_run_q)
    else $error("no wake on interrupt");
  chk_low_power_rc_osc_fs: assert property (
    failsafe_enable && switch_enable_fuse && sys_clk_run_q
      |-> ##[0:3] osc_enable_q[`CSSP_SRC_LOW_POWER_RC_OSC])
    else $error("low-power RC off with monitor on");
endmodule // cssp_clk_ctrl_assertions

// ===== cssp_clk_ctrl_tb.sv
// Testbench for the clock switch and power-save controller.
// Assumes cssp_osc_model as the oscillators; checker bound below.
`timescale 1ns/10ps
`include "cssp_consts.vh"

module cssp_clk_ctrl_tb;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg fuse = 1'b1;
  reg fs_en = 1'b1;
  reg wd_en = 1'b1;
  reg stall = 1'b0;
  reg failed = 1'b0;
  reg ps = 1'b0;
  reg ps_idle = 1'b0;
  reg wake = 1'b0;
  reg wd_to = 1'b0;
  reg trap_seen = 1'b0;
  reg wd_seen = 1'b0;
  reg [15:0] rdata;
  integer n_errors = 0;
  integer checked = 0;
  integer cycles = 0;
  wire [15:0] rd_q;
  wire [5:0] rdy, en;
  wire [2:0] sel;
  wire st, lk, tick, s_run, c_run, p_run, fs_act, trap, wd_clr;

  always #2 core_clk = ~core_clk;

  cssp_osc_model cssp_osc_model_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .osc_enable_q(en), .stall(stall),
    .osc_ready(rdy), .osc_startup_timer_done(st), .pll_locked(lk),
    .target_clk_tick(tick));

  cssp_clk_ctrl #(.SETTLE(4)) cssp_clk_ctrl_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rd_q),
    .switch_enable_fuse(fuse), .failsafe_enable(fs_en),
    .watchdog_enable(wd_en), .osc_is_crystal(6'h0C), .osc_ready(rdy),
    .osc_startup_timer_done(st), .pll_locked(lk),
    .target_clk_tick(tick), .osc_failed(failed),
    .power_save_instr(ps), .power_save_idle(ps_idle),
    .irq_wake(wake), .watchdog_timeout(wd_to), .osc_enable_q(en),
    .sys_clk_sel_q(sel), .sys_clk_run_q(s_run), .cpu_clk_run_q(c_run),
    .periph_clk_run_q(p_run), .failsafe_active_q(fs_act),
    .clock_fail_trap_q(trap), .watchdog_clear_q(wd_clr));

  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (trap === 1'b1)
      trap_seen <= 1'b1;
    if (wd_clr === 1'b1)
      wd_seen <= 1'b1;
    if (cycles == 5000)
    begin
      n_errors = n_errors + 1;
      results;
    end
  end

  task check(input string name, input [15:0] seen, input [15:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task results;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task wr(input [3:0] a, input [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    // Data stand for this one cycle; take them mid-cycle, end on an edge
    @(negedge core_clk);
    rdata = rd_q;
    @(posedge core_clk);
  endtask

  // One unlock opens both bytes of the control word
  task request(input [2:0] src);
    wr(`CSSP_OFF_STATUS, {8'h00, `CSSP_KEY1});
    wr(`CSSP_OFF_STATUS, {8'h00, `CSSP_KEY2});
    // Fail flag bit written as one, so only hardware may clear it
    wr(`CSSP_OFF_OSCCTL, {5'h00, src, 8'h09});
  endtask

  task wait_done;
    integer k;
    for (k = 0; k < 60; k = k + 1)
    begin
      rd(`CSSP_OFF_OSCCTL);
      if (rdata[0] === 1'b0)
        k = 60;
    end
    check("request bit", rdata[0], 1'b0);
  endtask

  task pulse_ps(input idle);
    @(posedge core_clk);
    ps <= 1'b1;
    ps_idle <= idle;
    @(posedge core_clk);
    ps <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  task t_refused;
    request(`CSSP_SRC_FRC);
    wait_done;
    check("enables", en, 6'h21);
    wr(`CSSP_OFF_STATUS, {8'h00, `CSSP_KEY1});
    wr(`CSSP_OFF_STATUS, 16'h0011);
    wr(`CSSP_OFF_OSCCTL, {5'h00, `CSSP_SRC_PRI, 8'h01});
    wait_done;
    check("current", rdata[14:12], `CSSP_SRC_FRC);
    fuse <= 1'b0;
    request(`CSSP_SRC_PRI);
    wait_done;
    check("current", rdata[14:12], `CSSP_SRC_FRC);
    check("requested", rdata[10:8], `CSSP_SRC_FRC);
    fuse <= 1'b1;
  endtask

  task t_switch_fail;
    request(`CSSP_SRC_PRI);
    wait_done;
    check("current", rdata[14:12], `CSSP_SRC_PRI);
    check("sel", sel, `CSSP_SRC_PRI);
    check("old source on", en[0], 1'b0);
    failed <= 1'b1;
    repeat (20) @(posedge core_clk);
    failed <= 1'b0;
    check("trap", trap_seen, 1'b1);
    check("sel", sel, `CSSP_SRC_FRC);
    rd(`CSSP_OFF_OSCCTL);
    check("fail flag", rdata[3], 1'b1);
  endtask

  // A switch to PRIPLL stays pending on fast RC while the sources are stalled
  task t_pending;
    stall <= 1'b1;
    request(`CSSP_SRC_PRIPLL);
    repeat (40) @(posedge core_clk);
    rd(`CSSP_OFF_OSCCTL);
    check("request bit", rdata[0], 1'b1);
    check("fail flag", rdata[3], 1'b0);
    check("sel", sel, `CSSP_SRC_FRC);
    stall <= 1'b0;
    wait_done;
    check("current", rdata[14:12], `CSSP_SRC_PRIPLL);
    check("sel", sel, `CSSP_SRC_PRIPLL);
  endtask

  task t_power;
    pulse_ps(`CSSP_PS_SLEEP);
    check("sys run", s_run, 1'b0);
    check("low_power_rc_osc", en[`CSSP_SRC_LOW_POWER_RC_OSC], 1'b1);
    check("sleep osc", en[`CSSP_SRC_PRIPLL], 1'b0);
    check("wd clear", wd_seen, 1'b1);
    check("monitor", fs_act, 1'b0);
    @(posedge core_clk);
    wake <= 1'b1;
    @(posedge core_clk);
    wake <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("sys run", s_run, 1'b1);
    check("sel", sel, `CSSP_SRC_PRIPLL);
    check("monitor", fs_act, 1'b1);
    pulse_ps(`CSSP_PS_IDLE);
    check("cpu run", c_run, 1'b0);
    check("periph run", p_run, 1'b1);
    check("low_power_rc_osc", en[`CSSP_SRC_LOW_POWER_RC_OSC], 1'b1);
    @(posedge core_clk);
    wd_to <= 1'b1;
    @(posedge core_clk);
    wd_to <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("cpu run", c_run, 1'b1);
    // Wake arriving with the instruction: Idle is entered, then left
    @(posedge core_clk);
    ps <= 1'b1;
    wake <= 1'b1;
    @(posedge core_clk);
    ps <= 1'b0;
    wake <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("held wake", c_run, 1'b1);
  endtask

  initial
  begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(`CSSP_OFF_PWRCTL);
    check("unused reg", rdata, 16'h0000);
    t_refused;
    t_switch_fail;
    t_pending;
    t_power;
    results;
  end
endmodule // cssp_clk_ctrl_tb

bind cssp_clk_ctrl cssp_clk_ctrl_assertions cssp_clk_ctrl_assertions_i (
  .core_clk(core_clk), .sys_rst(sys_rst),
  .power_save_instr(power_save_instr), .power_save_idle(power_save_idle),
  .irq_wake(irq_wake), .watchdog_enable(watchdog_enable),
  .failsafe_enable(failsafe_enable),
  .switch_enable_fuse(switch_enable_fuse), .osc_enable_q(osc_enable_q),
  .sys_clk_sel_q(sys_clk_sel_q), .sys_clk_run_q(sys_clk_run_q),
  .cpu_clk_run_q(cpu_clk_run_q), .periph_clk_run_q(periph_clk_run_q),
  .failsafe_active_q(failsafe_active_q),
  .clock_fail_trap_q(clock_fail_trap_q),
  .watchdog_clear_q(watchdog_clear_q));

// ===== cssp_consts.vh
// Constants for the clock switch and power-save controller.
// Assumes inclusion by its bare name from each design file.
`ifndef CSSP_CONSTS_VH
`define CSSP_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CSSP_OFF_OSCCTL 4'h0
`define CSSP_OFF_PWRCTL 4'h1
`define CSSP_OFF_STATUS 4'h2

// ----------------------------------------------------------------
// Field positions in the oscillator control register
// ----------------------------------------------------------------
`define CSSP_CUR_HI 14
`define CSSP_CUR_LO 12
`define CSSP_REQ_HI 10
`define CSSP_REQ_LO 8
`define CSSP_BIT_LOCK 5
`define CSSP_BIT_FAIL 3
`define CSSP_BIT_SECEN 1
`define CSSP_BIT_SWREQ 0

// ----------------------------------------------------------------
// Source codes
// ----------------------------------------------------------------
`define CSSP_SRC_FRC 3'h0
`define CSSP_SRC_FAST_RC_WITH_PLL 3'h1
`define CSSP_SRC_PRI 3'h2
`define CSSP_SRC_PRIPLL 3'h3
`define CSSP_SRC_SEC 3'h4
`define CSSP_SRC_LOW_POWER_RC_OSC 3'h5

// ----------------------------------------------------------------
// Power-save operands, reset values, timing and unlock keys
// ----------------------------------------------------------------
`define CSSP_PS_SLEEP 1'b0
`define CSSP_PS_IDLE 1'b1
`define CSSP_RST_SRC 3'h0
`define CSSP_SETTLE_CYCLES 4'hA
`define CSSP_KEY1 8'h57
`define CSSP_KEY2 8'hAA

`endif

// ===== cssp_osc_model.sv
// Oscillator bank model: ready, start-up timer, PLL lock and tick.
// Assumes enables from the controller; stall keeps all sources unready.
`timescale 1ns/10ps

module cssp_osc_model (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Control
  input wire [5:0] osc_enable_q,
  input wire stall,
  // Status
  output reg [5:0] osc_ready,
  output wire osc_startup_timer_done,
  output wire pll_locked,
  output reg target_clk_tick
);
  reg [2:0] warm_q;
  reg [5:0] en_q;

  assign osc_startup_timer_done = (warm_q == 3'h7) && !stall;
  assign pll_locked = (warm_q == 3'h7) && !stall;

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      warm_q <= 3'h0;
      en_q <= 6'h00;
      osc_ready <= 6'h00;
      target_clk_tick <= 1'b0;
    end
    else
    begin
      en_q <= osc_enable_q;
      osc_ready <= osc_enable_q & en_q & {6{!stall}};
      // A new enable restarts warm-up, so lock never comes early
      if (osc_enable_q != en_q)
        warm_q <= 3'h0;
      else if (warm_q != 3'h7)
        warm_q <= warm_q + 3'h1;
      target_clk_tick <= !target_clk_tick && !stall;
    end
  end
endmodule // cssp_osc_model

// ===== cssp_settle_cnt.v
// Settling counter: counts edges of the target clock, seen as a pulse.
// Assumes the tick is already synchronous to core_clk.
`timescale 1ns/10ps
`include "cssp_consts.vh"

module cssp_settle_cnt #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] COUNT = `CSSP_SETTLE_CYCLES
) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Control
  input wire start,
  input wire tick,
  output reg done_q
);

  reg [WIDTH-1:0] cnt_q;

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= {WIDTH{1'b0}};
      done_q <= 1'b0;
    end
    else if (start)
    begin
      cnt_q <= {WIDTH{1'b0}};
      done_q <= 1'b0;
    end
    else if (tick && !done_q)
    begin
      cnt_q <= cnt_q + 1'b1;
      done_q <= (cnt_q == COUNT - 1'b1);
    end
  end

endmodule // cssp_settle_cnt
